// [hdl/standstill_current_reduction.sv]
// standstill current reduction controller with wishbone registers
// Notes on behaviour
// R1 - reduction only while standstill_enable is 1; otherwise run current stays applied
// R2 - count programmed delay after last step; reduce only if no step arrives
// R3 - after delay, drop effective code by one per fall interval to holding level
// R4 - fall rate code 0 drops at once; code 1 gives 1 ms per code
// R5 - delay field counts 16 ms units; code 0 reserved
// R6 - readable flag high while in reduced-current standstill
// R7 - new step during delay, ramp or standstill restores run current, restarts delay
// R8 - run level from run setting field, holding level from holding field
// R9 - software cycles enable off then on to change holding level in standstill
// R10 - software keeps holding level between auto-torque max and min
// R11 - higher codes scale linearly: code ms per step, code times 16 ms delay
// R12 - holding at or above run: no lowering, still enter standstill and flag
//
// Decided for this implementation: the address map and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module standstill_current_reduction
  import standstill_pkg::*;
#(
  parameter int CUR_WIDTH   = 8,
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic                 stepPin,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output var  logic [31:0]          wb_dat_o,
  output var  logic                 wb_ack_o,
  output var  logic [CUR_WIDTH-1:0] effectiveCurrent,
  output var  logic                 standstillActiveFlag
);
  initial begin
    if (CUR_WIDTH < 1 || CUR_WIDTH > 8) $error("CUR_WIDTH must be 1..8");
  end

  typedef struct packed {
    logic                 standstillEnable;
    logic [3:0]           standstillFallRate;
    logic [5:0]           standstillDelay;
    logic [CUR_WIDTH-1:0] runCurrentSetting;
    logic [CUR_WIDTH-1:0] holdingCurrentSetting;
    phase_e               phase;
    logic [9:0]           msCount;
    logic [CUR_WIDTH-1:0] effective;
    logic                 flag;
    logic                 ack;
    logic [31:0]          rdata;
  } state_s;

  state_s stReg;
  state_s stNext;
  logic   stepEdge;
  logic   msTick;

  step_sync u_step_sync (
    .mclk     (mclk),
    .sys_rst  (sys_rst),
    .stepPin  (stepPin),
    .stepEdge (stepEdge)
  );

  // ms grid restarts on each step so the delay counts from that pulse
  ms_tick_gen #(.CYCLES(TICK_CYCLES_P)) u_ms_tick (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .restart (stepEdge),
    .tick    (msTick)
  );

  // byte-lane merge for 32-bit writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : merge

  // register images for readback and write merging
  logic [31:0] ctrlImg;
  logic [31:0] timingImg;
  logic [31:0] currentImg;
  logic [31:0] statusImg;
  always_comb begin
    ctrlImg    = '0;
    timingImg  = '0;
    currentImg = '0;
    statusImg  = '0;
    ctrlImg[ENABLE_BIT]                     = stReg.standstillEnable;
    timingImg[FALL_LSB +: 4]                = stReg.standstillFallRate;
    timingImg[DELAY_LSB +: 6]               = stReg.standstillDelay;
    currentImg[RUN_LSB +: CUR_WIDTH]        = stReg.runCurrentSetting;
    currentImg[HOLD_LSB +: CUR_WIDTH]       = stReg.holdingCurrentSetting;
    statusImg[FLAG_BIT]                     = stReg.flag;
    statusImg[PHASE_LSB +: 2]               = stReg.phase;
    statusImg[EFFECTIVE_LSB +: CUR_WIDTH]   = stReg.effective;
  end

  logic        wbReq;
  logic [31:0] wVal;
  logic        holdReached;
  logic [9:0]  delayMs;
  always_comb begin
    wbReq       = wb_cyc_i & wb_stb_i & ~stReg.ack;
    delayMs     = 10'(stReg.standstillDelay) * 10'(DELAY_UNIT_MS); // see R5 see R11
    holdReached = stReg.effective <= stReg.holdingCurrentSetting;
  end

  always_comb begin
    wVal         = '0;
    stNext       = stReg;
    stNext.ack   = wbReq;
    stNext.rdata = '0;
    // register bus: one-cycle ack, unmapped reads zero, unmapped writes dropped
    if (wbReq) begin
      case (wb_adr_i)
        CTRL_OFFSET: begin
          stNext.rdata = ctrlImg;
          if (wb_we_i) begin
            wVal = merge(ctrlImg, wb_dat_i, wb_sel_i);
            stNext.standstillEnable = wVal[ENABLE_BIT];
          end
        end
        TIMING_OFFSET: begin
          stNext.rdata = timingImg;
          if (wb_we_i) begin
            wVal = merge(timingImg, wb_dat_i, wb_sel_i);
            stNext.standstillFallRate = wVal[FALL_LSB +: 4];
            stNext.standstillDelay    = wVal[DELAY_LSB +: 6];
          end
        end
        CURRENT_OFFSET: begin
          stNext.rdata = currentImg;
          if (wb_we_i) begin
            wVal = merge(currentImg, wb_dat_i, wb_sel_i);
            stNext.runCurrentSetting     = wVal[RUN_LSB +: CUR_WIDTH]; // see R8
            stNext.holdingCurrentSetting = wVal[HOLD_LSB +: CUR_WIDTH]; // see R8
          end
        end
        STATUS_OFFSET: begin
          stNext.rdata = statusImg;
        end
        default: begin
          stNext.rdata = '0;
        end
      endcase
    end

    // standstill sequencer, uses the settings as they stand this cycle
    if (!stReg.standstillEnable) begin
      stNext.phase     = RUN; // see R1 see R9
      stNext.msCount   = '0;
      stNext.effective = stReg.runCurrentSetting; // see R1
      stNext.flag      = 1'b0;
    end else if (stepEdge) begin
      stNext.phase     = WAIT_IDLE; // see R7
      stNext.msCount   = '0; // see R7
      stNext.effective = stReg.runCurrentSetting; // see R7
      stNext.flag      = 1'b0;
    end else begin
      case (stReg.phase)
        RUN: begin
          // enable just set while idle: start counting from now
          stNext.phase     = WAIT_IDLE;
          stNext.msCount   = '0;
          stNext.effective = stReg.runCurrentSetting;
        end
        WAIT_IDLE: begin
          stNext.effective = stReg.runCurrentSetting;
          if (msTick) begin
            if (stReg.msCount + 10'h1 >= delayMs) begin
              stNext.msCount = '0; // see R2
              if (stReg.standstillFallRate == 4'h0 || holdReached) begin
                stNext.phase     = HOLD; // see R4 see R12
                stNext.flag      = 1'b1; // see R6
                if (!holdReached) begin
                  stNext.effective = stReg.holdingCurrentSetting; // see R4
                end
              end else begin
                stNext.phase = RAMP; // see R2
              end
            end else begin
              stNext.msCount = stReg.msCount + 10'h1;
            end
          end
        end
        RAMP: begin
          stNext.flag = 1'b1; // see R6
          if (msTick) begin
            if (stReg.msCount + 10'h1 >= 10'(stReg.standstillFallRate)) begin
              stNext.msCount = '0; // see R3 see R11
              if (stReg.effective > stReg.holdingCurrentSetting) begin
                stNext.effective = stReg.effective - 1'b1; // see R3
              end
              if (stReg.effective <= stReg.holdingCurrentSetting + 1'b1) begin
                stNext.phase = HOLD; // see R3
              end
            end else begin
              stNext.msCount = stReg.msCount + 10'h1;
            end
          end
        end
        HOLD: begin
          stNext.flag = 1'b1; // see R6 see R12
        end
        default: begin
          stNext.phase = RUN;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stReg                       <= '0;
      stReg.standstillEnable      <= ENABLE_RESET;
      stReg.standstillFallRate    <= FALL_RESET;
      stReg.standstillDelay       <= DELAY_RESET;
      stReg.runCurrentSetting     <= RUN_RESET[CUR_WIDTH-1:0];
      stReg.holdingCurrentSetting <= HOLD_RESET[CUR_WIDTH-1:0];
      stReg.effective             <= RUN_RESET[CUR_WIDTH-1:0];
      stReg.phase                 <= RUN;
    end else begin
      stReg <= stNext;
    end
  end

  // outputs straight from the state flops
  assign wb_dat_o             = stReg.rdata;
  assign wb_ack_o             = stReg.ack;
  assign effectiveCurrent     = stReg.effective;
  assign standstillActiveFlag = stReg.flag;
endmodule : standstill_current_reduction
`default_nettype wire

// [hdl/standstill_pkg.sv]
// shared constants for the standstill current reduction block
package standstill_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [3:0] CTRL_OFFSET      = 4'h0;
  localparam logic [3:0] TIMING_OFFSET    = 4'h4;
  localparam logic [3:0] CURRENT_OFFSET   = 4'h8;
  localparam logic [3:0] STATUS_OFFSET    = 4'hC;
  // field positions
  localparam int ENABLE_BIT      = 0;
  localparam int FALL_LSB        = 0;
  localparam int DELAY_LSB       = 8;
  localparam int RUN_LSB         = 0;
  localparam int HOLD_LSB        = 8;
  localparam int FLAG_BIT        = 0;
  localparam int PHASE_LSB       = 8;
  localparam int EFFECTIVE_LSB   = 16;
  // reset values
  localparam logic       ENABLE_RESET = 1'b0;
  localparam logic [3:0] FALL_RESET   = 4'h1;
  localparam logic [5:0] DELAY_RESET  = 6'h01;
  localparam logic [7:0] RUN_RESET    = 8'hFF;
  localparam logic [7:0] HOLD_RESET   = 8'h80;
  // timing
  localparam int CLK_MHZ     = 100;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
  localparam int DELAY_UNIT_MS = 16;
  localparam int FALL_UNIT_MS  = 1;
  // control states
  typedef enum logic [1:0] {RUN, WAIT_IDLE, RAMP, HOLD} phase_e;
endpackage : standstill_pkg

// [hdl/ms_tick_gen.sv]
// millisecond enable pulse divider
`timescale 1ns/10ps
`default_nettype none
module ms_tick_gen #(
  parameter int CYCLES = 100000
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic restart,
  output var  logic tick
);
  initial begin
    if (CYCLES < 2) $error("ms_tick_gen: CYCLES too small");
  end
  typedef struct packed {
    logic [31:0] count;
    logic        tick;
  } div_s;
  div_s divReg;
  div_s divNext;
  // restart aligns the ms grid to the latest step pulse
  always_comb begin
    divNext      = divReg;
    divNext.tick = 1'b0;
    if (restart) begin
      divNext.count = 32'h0;
    end else if (divReg.count == 32'(CYCLES - 1)) begin
      divNext.count = 32'h0;
      divNext.tick  = 1'b1;
    end else begin
      divNext.count = divReg.count + 32'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      divReg <= '0;
    end else begin
      divReg <= divNext;
    end
  end
  assign tick = divReg.tick;
endmodule : ms_tick_gen
`default_nettype wire

// [hdl/step_sync.sv]
// two-flop synchroniser and rising edge detector for the step pin
`timescale 1ns/10ps
`default_nettype none
module step_sync (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic stepPin,
  output var  logic stepEdge
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic edgeSeen;
  } sync_s;
  sync_s syncReg;
  sync_s syncNext;
  // only the second stage feeds the edge detector
  always_comb begin
    syncNext          = syncReg;
    syncNext.meta     = stepPin;
    syncNext.sync     = syncReg.meta;
    syncNext.last     = syncReg.sync;
    syncNext.edgeSeen = syncReg.sync & ~syncReg.last;
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end
  assign stepEdge = syncReg.edgeSeen;
endmodule : step_sync
`default_nettype wire

// [testbench/scr_properties.sv]
// port checker for the standstill current reduction block
`timescale 1ns/10ps
`default_nettype none
module scr_properties
  import standstill_pkg::*;
#(parameter int CUR_WIDTH = 8, parameter int TICK_CYCLES_P = 10) (
  input wire logic                 mclk,
  input wire logic                 sys_rst,
  input wire logic                 stepPin,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic [CUR_WIDTH-1:0] effectiveCurrent,
  input wire logic                 standstillActiveFlag
);
  logic [15:0]          quietReg;
  logic [15:0]          sinceReg;
  logic [CUR_WIDTH-1:0] prevReg;
  // saturating ages: since the step pin, since the last current change
  always_ff @(posedge mclk) begin
    quietReg <= (sys_rst || stepPin) ? '0 : quietReg + 16'(quietReg != 16'hFFFF);
    sinceReg <= (sys_rst || effectiveCurrent != prevReg) ? '0 : sinceReg + 16'(sinceReg != 16'hFFFF);
    prevReg <= effectiveCurrent;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  chk_reset_state: assert property (disable iff (1'b0)
    sys_rst |=> effectiveCurrent == RUN_RESET && !standstillActiveFlag && !wb_ack_o)
    else $error("wrong state after reset");
  chk_step_restore: assert property ($rose(stepPin) |-> ##[1:6] !standstillActiveFlag)
    else $error("step did not leave standstill");
  chk_delay_quiet: assert property ($rose(standstillActiveFlag) |-> quietReg >= 16'(15 * TICK_CYCLES_P))
    else $error("standstill entered too soon after step");
  chk_fall_one: assert property (standstillActiveFlag && $past(standstillActiveFlag) &&
    effectiveCurrent != $past(effectiveCurrent) |-> effectiveCurrent == $past(effectiveCurrent) - 1'b1)
    else $error("ramp step not one code");
  chk_fall_gap: assert property (standstillActiveFlag && $past(standstillActiveFlag) &&
    effectiveCurrent < $past(effectiveCurrent) |-> sinceReg >= 16'(TICK_CYCLES_P - 1))
    else $error("ramp steps too close");
  cov_flag: cover property ($rose(standstillActiveFlag));
  cov_fall: cover property (standstillActiveFlag && effectiveCurrent < $past(effectiveCurrent));
  cov_write: cover property (wb_ack_o && wb_we_i);
endmodule : scr_properties
bind standstill_current_reduction scr_properties #(.CUR_WIDTH(CUR_WIDTH), .TICK_CYCLES_P(TICK_CYCLES_P))
  scr_properties_i (.mclk(mclk), .sys_rst(sys_rst), .stepPin(stepPin), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .effectiveCurrent(effectiveCurrent), .standstillActiveFlag(standstillActiveFlag));
`default_nettype wire

// [testbench/step_source.sv]
// step pulse source standing in for the motion controller
`timescale 1ns/10ps
`default_nettype none
module step_source (
  input  wire logic mclk,
  input  wire logic go,
  output var  logic stepPin
);
  logic [1:0] cntReg = 2'h0;
  // three cycles high, beyond the two the synchroniser needs
  always_ff @(posedge mclk) cntReg <= go ? 2'h3 : cntReg - 2'(cntReg != 2'h0);
  assign stepPin = (cntReg != 2'h0);
endmodule : step_source
`default_nettype wire

// [testbench/standstill_current_reduction_tb_top.sv]
// self-checking bench for the standstill current reduction block
`timescale 1ns/10ps
`default_nettype none
module standstill_current_reduction_tb_top;
  import standstill_pkg::*;
  localparam int T = 10;
  logic mclk = 1'b0, sysRst = 1'b1, go = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] dat = 32'h0, datO, r;
  logic        ack, stepPin, flag;
  logic [7:0]  eff, runC, holdC, expFin;
  int          bad_count = 0, n_compared = 0, n, fall, dly, codes;
  // 100 MHz
  always #5 mclk = ~mclk;
  standstill_current_reduction #(.TICK_CYCLES_P(T)) standstill_current_reduction_i (
    .mclk(mclk), .sys_rst(sysRst), .stepPin(stepPin), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(datO),
    .wb_ack_o(ack), .effectiveCurrent(eff), .standstillActiveFlag(flag));
  step_source step_source_i (.mclk(mclk), .go(go), .stepPin(stepPin));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one classic cycle; data taken at the edge where ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    r = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk);
    check("ack", 32'(k < 20), 32'h1);
  endtask : wb
  task automatic pulse();
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
  endtask : pulse
  // bounded wait for the flag, or for the expected final current
  task automatic waitOn(input bit onEff);
    n = 0;
    while (!(onEff ? eff === expFin : flag === 1'b1) && n < 3000) begin
      @(posedge mclk);
      n++;
    end
  endtask : waitOn
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // watchdog: the tests need well under 30k cycles
  initial begin
    #300_000;
    bad_count++;
    print_verdict();
  end
  initial begin
    n = $urandom(48481);
    repeat (8) @(posedge mclk);
    sysRst <= 1'b0;
    wb(0, CTRL_OFFSET, 0);
    check("ctrl", r, 32'(ENABLE_RESET));
    wb(0, TIMING_OFFSET, 0);
    check("timing", r, 32'(FALL_RESET) | 32'(DELAY_RESET) << DELAY_LSB);
    wb(0, CURRENT_OFFSET, 0);
    check("current", r, 32'(RUN_RESET) | 32'(HOLD_RESET) << HOLD_LSB);
    wb(0, 4'h2, 0);
    check("unmapped", r, 32'h0);
    wb(1, STATUS_OFFSET, 32'hFFFFFFFF);
    wb(0, STATUS_OFFSET, 0);
    check("status", r, 32'(RUN_RESET) << EFFECTIVE_LSB);
    $display("register test done");
    // steps while disabled never reduce
    pulse();
    repeat (400) @(posedge mclk);
    check("flag off", 32'(flag), 32'h0);
    check("run kept", 32'(eff), 32'(RUN_RESET));
    $display("disabled test done");
    // 0: instant drop, 1: hold not below run, 2: enable cleared, 3: early step
    for (int i = 0; i < 8; i++) begin
      runC = 8'h20 + 8'($urandom % 32);
      holdC = (i == 1) ? runC + 8'($urandom % 4) : runC - 8'h1 - 8'($urandom % 8);
      fall = (i == 0) ? 0 : 1 + $urandom % 3;
      dly = 1 + $urandom % 2;
      expFin = (holdC >= runC) ? runC : holdC;
      codes = runC - expFin;
      wb(1, CURRENT_OFFSET, 32'(runC) | 32'(holdC) << HOLD_LSB);
      wb(1, TIMING_OFFSET, 32'(fall) | 32'(dly) << DELAY_LSB);
      wb(1, CTRL_OFFSET, 32'h1);
      if (i == 3) begin
        pulse();
        repeat (100) @(posedge mclk);
      end
      pulse();
      waitOn(0);
      check("delay", 32'(n >= dly * 16 * T - 2 && n <= dly * 16 * T + T + 8), 1);
      waitOn(1);
      check("fall", 32'(n >= (codes - 1) * fall * T - 2 && n <= codes * fall * T + T + 2), 1);
      check("hold", 32'(eff), 32'(expFin));
      check("flag", 32'(flag), 32'h1);
      wb(0, STATUS_OFFSET, 0);
      check("status", r, 32'(expFin) << EFFECTIVE_LSB | 32'h3 << PHASE_LSB | 32'h1);
      if (i == 2) wb(1, CTRL_OFFSET, 0);
      else pulse();
      repeat (6) @(posedge mclk);
      check("restore", 32'(eff), 32'(runC));
      check("flag low", 32'(flag), 32'h0);
      wb(1, CTRL_OFFSET, 0);
      $display("reduction test %0d done", i);
    end
    print_verdict();
  end
endmodule : standstill_current_reduction_tb_top
`default_nettype wire
